/* bench/tb_tgp_top.sv */
// Testbench: register access, gate selection, period timer and match flag
`timescale 1ns/1ps
module tb_tgp_top;
  import tgp_pkg::*;
  logic clk, reset, pin, aux, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv;
  logic pce, pm, pmp, irq, hit;
  logic [TGP_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] rd;
  int error_cnt, n_checks, cnt;
  int ps[3] = '{0, 2, 15};

  tgp_top i_dut (.clk(clk), .reset(reset), .external_gate_pin(pin), .aux_overflow(aux),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .primary_count_enable(pce), .period_match(pm),
    .period_match_pulse(pmp), .match_irq(irq));

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Address and data offered together, each released once taken
  task automatic wr_reg(input logic [11:0] i, input logic [7:0] d, input logic [1:0] er);
    logic done;
    done = 0;
    @(posedge clk);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h00_0000, d};
    awv <= 1;
    wv <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge clk);
      if (awv && awr === 1'b1) awv <= 0;
      if (wv && wr === 1'b1) wv <= 0;
      if (bv === 1'b1) begin
        done = 1;
        bready <= 0;
        chk({6'h00, bresp}, {6'h00, er});
      end
    end
  endtask
  task automatic rd_reg(input logic [11:0] i, input logic [1:0] er);
    logic done;
    done = 0;
    @(posedge clk);
    araddr <= {2'b00, i, 2'b00};
    arv <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge clk);
      if (arv && arr === 1'b1) arv <= 0;
      if (rv === 1'b1) begin
        done = 1;
        rready <= 0;
        rd = rdata[7:0];
        chk({6'h00, rresp}, {6'h00, er});
      end
    end
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    reset = 1;
    {pin, aux, awv, wv, bready, arv, rready} = 7'h00;
    awaddr = 0;
    araddr = 0;
    wdata = 0;
    wstrb = 4'hf;
    error_cnt = 0;
    n_checks = 0;
    wt(5);
    reset <= 0;
    rd_reg(TGP_IDX_PCTRL, TGP_RESP_OKAY);
    chk(rd, TGP_PCTRL_RST);
    rd_reg(TGP_IDX_TVAL, TGP_RESP_OKAY);
    chk(rd, 8'h00);
    rd_reg(TGP_IDX_PLIMIT, TGP_RESP_OKAY);
    chk(rd, 8'hff);
    rd_reg(TGP_IDX_IRQ, TGP_RESP_OKAY);
    chk(rd, 8'h00);
    rd_reg(12'h000, TGP_RESP_SLVERR);
    chk(rd, 8'h00);
    wr_reg(12'h000, 8'hff, TGP_RESP_SLVERR);
    chk(8'(pce), 8'h01);
    // Pin is synchronised, so every level change gets a settling wait
    for (int en = 0; en < 2; en++) begin
      for (int pol = 0; pol < 2; pol++) begin
        for (int p = 0; p < 2; p++) begin
          pin <= p[0];
          wr_reg(TGP_IDX_GCTRL, {en[0], pol[0], 6'h00}, TGP_RESP_OKAY);
          wt(6);
          chk(8'(pce), 8'(!en || pol == p));
          rd_reg(TGP_IDX_GCTRL, TGP_RESP_OKAY);
          chk(8'(rd[TGP_GC_VAL]), 8'(pol == p));
        end
      end
    end
    for (int pol = 0; pol < 2; pol++) begin
      wr_reg(TGP_IDX_GCTRL, {1'b1, pol[0], 6'h03}, TGP_RESP_OKAY);
      chk(8'(pce), 8'(!pol));
    end
    wr_reg(TGP_IDX_GCTRL, 8'hc1, TGP_RESP_OKAY);
    hit = 0;
    aux <= 1;
    repeat (4) begin
      @(posedge clk);
      hit |= pce;
      aux <= 0;
    end
    chk(8'(hit), 8'h01);
    chk(8'(pce), 8'h00);
    pin <= 0;
    wr_reg(TGP_IDX_GCTRL, 8'hc0, TGP_RESP_OKAY);
    wr_reg(TGP_IDX_GCTRL, 8'he0, TGP_RESP_OKAY);
    wt(6);
    chk(8'(pce), 8'h00);
    for (int k = 0; k < 3; k++) begin
      pin <= !pin;
      wt(6);
      chk(8'(pce), 8'(k < 2));
    end
    for (int tm = 0; tm < 2; tm++) begin
      pin <= 0;
      wr_reg(TGP_IDX_GCTRL, 8'hc0, TGP_RESP_OKAY);
      wr_reg(TGP_IDX_GCTRL, {2'b11, tm[0], 5'h10}, TGP_RESP_OKAY);
      wr_reg(TGP_IDX_GCTRL, {2'b11, tm[0], 5'h18}, TGP_RESP_OKAY);
      wt(6);
      rd_reg(TGP_IDX_GCTRL, TGP_RESP_OKAY);
      chk(8'(rd[TGP_GC_GO]), 8'h01);
      for (int k = 0; k < 5; k++) begin
        pin <= !k[0];
        wt(6);
        chk(8'(pce), 8'(k == 0 || (tm == 1 && k == 1)));
      end
      rd_reg(TGP_IDX_GCTRL, TGP_RESP_OKAY);
      chk(8'(rd[TGP_GC_GO]), 8'h00);
    end
    wr_reg(TGP_IDX_GCTRL, 8'hd8, TGP_RESP_OKAY);
    wr_reg(TGP_IDX_GCTRL, 8'hc8, TGP_RESP_OKAY);
    rd_reg(TGP_IDX_GCTRL, TGP_RESP_OKAY);
    chk(8'(rd[TGP_GC_GO]), 8'h00);
    wr_reg(TGP_IDX_PLIMIT, 8'h37, TGP_RESP_OKAY);
    rd_reg(TGP_IDX_PLIMIT, TGP_RESP_OKAY);
    chk(rd, 8'h37);
    wr_reg(TGP_IDX_TVAL, 8'h2a, TGP_RESP_OKAY);
    wr_reg(TGP_IDX_PCTRL, 8'hf8, TGP_RESP_OKAY);
    rd_reg(TGP_IDX_TVAL, TGP_RESP_OKAY);
    chk(rd, 8'h2a);
    rd_reg(TGP_IDX_PCTRL, TGP_RESP_OKAY);
    chk(rd, 8'h78);
    // First period after a control write is skipped, it starts mid count
    wr_reg(TGP_IDX_PLIMIT, 8'h04, TGP_RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      wr_reg(TGP_IDX_PCTRL, {5'h00, 1'b1, c[1:0]}, TGP_RESP_OKAY);
      while (pmp !== 1'b1) @(posedge clk);
      cnt = 0;
      do begin
        @(posedge clk);
        cnt++;
      end while (pmp !== 1'b1);
      chk(8'(cnt), 8'(5 * (c == 0 ? 1 : (c == 1 ? 4 : 16))));
    end
    wr_reg(TGP_IDX_PLIMIT, 8'h02, TGP_RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      wr_reg(TGP_IDX_PCTRL, {1'b0, ps[i][3:0], 3'b000}, TGP_RESP_OKAY);
      wr_reg(TGP_IDX_TVAL, 8'h00, TGP_RESP_OKAY);
      wr_reg(TGP_IDX_IRQ, 8'h02, TGP_RESP_OKAY);
      wr_reg(TGP_IDX_PCTRL, {1'b0, ps[i][3:0], 3'b100}, TGP_RESP_OKAY);
      cnt = 0;
      while (irq !== 1'b1) begin
        @(posedge clk);
        if (pmp === 1'b1) cnt++;
      end
      chk(8'(cnt), 8'(ps[i] + 1));
    end
    for (int pol = 0; pol < 2; pol++) begin
      wr_reg(TGP_IDX_GCTRL, {1'b1, pol[0], 6'h02}, TGP_RESP_OKAY);
      while (pmp !== 1'b1) @(posedge clk);
      chk(8'(pce), 8'(pol));
      @(posedge clk);
      chk(8'(pce), 8'(!pol));
    end
    wr_reg(TGP_IDX_IRQ, 8'h01, TGP_RESP_OKAY);
    chk(8'(irq), 8'h00);
    rd_reg(TGP_IDX_IRQ, TGP_RESP_OKAY);
    chk(8'(rd[TGP_IRQ_FLAG]), 8'h01);
    wr_reg(TGP_IDX_PCTRL, 8'h00, TGP_RESP_OKAY);
    // Timer stopped, so equality stands as a level and no pulse follows
    wr_reg(TGP_IDX_TVAL, 8'h02, TGP_RESP_OKAY);
    chk(8'(pm), 8'h01);
    chk(8'(pmp), 8'h00);
    wr_reg(TGP_IDX_TVAL, 8'h01, TGP_RESP_OKAY);
    chk(8'(pm), 8'h00);
    wr_reg(TGP_IDX_IRQ, 8'h03, TGP_RESP_OKAY);
    chk(8'(irq), 8'h01);
    wr_reg(TGP_IDX_IRQ, 8'h02, TGP_RESP_OKAY);
    chk(8'(irq), 8'h00);
    end_sim;
  end

  initial begin
    wt(20000);
    error_cnt++;
    end_sim;
  end
endmodule

/* bench/tgp_top_asserts.sv */
// Checker: port-level properties of the timer gate block
`timescale 1ns/1ps
module tgp_top_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic [tgp_pkg::TGP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic primary_count_enable,
  input wire logic period_match,
  input wire logic period_match_pulse,
  input wire logic match_irq
);
  import tgp_pkg::*;
  localparam logic [15:0] GC_A = {2'b00, TGP_IDX_GCTRL, 2'b00};
  logic [7:0] g_sh_r;
  logic wr_take;
  // ----------------------------------------
  // Shadow of gate control, level and go bits dropped
  // ----------------------------------------
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_ff @(posedge clk) begin
    if (reset) begin
      g_sh_r <= TGP_GCTRL_RST;
    end else if (wr_take && s_axi_awaddr == GC_A && s_axi_wstrb[0]) begin
      g_sh_r <= s_axi_wdata[7:0] & 8'hf3;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Two cycles of stable shadow, since the register lands one edge after the shadow
  a_free_count: assert property (!g_sh_r[7] && $past(g_sh_r, 2) == g_sh_r |-> primary_count_enable)
    else $error("count enable low with gating off");
  a_match_gate: assert property (g_sh_r[7] && g_sh_r[5:0] == 6'h02 && $past(g_sh_r, 2) == g_sh_r
    |-> primary_count_enable == (period_match_pulse == g_sh_r[6]))
    else $error("match gate count enable wrong");
  a_none_source: assert property (g_sh_r[7] && g_sh_r[5:0] == 6'h03 && $past(g_sh_r, 2) == g_sh_r
    |-> primary_count_enable == !g_sh_r[6])
    else $error("unused source not a low gate");
  a_pulse_cause: assert property (period_match_pulse |-> $past(period_match))
    else $error("match pulse without match");
  a_reset_state: assert property ($past(reset) |-> primary_count_enable && !period_match
    && !match_irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state after reset wrong");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_turn: assert property (wr_take |-> !s_axi_bvalid ##2 s_axi_bvalid)
    else $error("write answer timing wrong");
  a_bus_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  c_match_count: cover property (period_match_pulse && primary_count_enable);
  c_irq_rise: cover property ($rose(match_irq));
  c_gate_hold: cover property (g_sh_r[7] && !primary_count_enable);
endmodule
bind tgp_top tgp_top_asserts i_chk (.*);

/* rtl/tgp_gate.sv */
// Gate path: source select, polarity, toggle flip-flop and single-pulse control
`timescale 1ns/1ps
module tgp_gate (
  input wire logic clk,
  input wire logic reset,
  input wire logic external_gate_pin,
  input wire logic aux_overflow,
  input wire logic match_pulse,
  input wire tgp_pkg::tgp_gate_cfg_s cfg,
  output logic count_enable,
  output logic gate_level,
  output logic go_clear
);
  import tgp_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic pin_q;
    logic g_prev;
    logic tff;
    logic gt_prev;
    logic sp_run;
  } tgp_gstate_s;

  tgp_gstate_s r;
  tgp_gstate_s n;
  logic g_raw;
  logic g;
  logic gt;
  logic gt_rise;
  logic gt_fall;
  logic gate_q;

  // ----------------------------------------
  // Gate evaluation
  // ----------------------------------------
  always_comb begin
    n = r;
    n.sync1 = external_gate_pin;
    n.sync2 = r.sync1;
    n.sync3 = r.sync2;
    // Pin level changes only once two stages agree
    if (r.sync2 == r.sync3) begin
      n.pin_q = r.sync2;
    end
    unique case (cfg.source)
      TGP_SRC_PIN: g_raw = r.pin_q;
      TGP_SRC_AUX: g_raw = aux_overflow;
      TGP_SRC_MATCH: g_raw = match_pulse;
      TGP_SRC_NONE: g_raw = 1'b0;
    endcase
    g = cfg.polarity ? g_raw : ~g_raw;
    n.g_prev = g;
    // Flop inverts on each incrementing edge, cleared while disabled
    n.tff = cfg.toggle ? (r.tff ^ (g & ~r.g_prev)) : 1'b0;
    gt = cfg.toggle ? r.tff : g;
    n.gt_prev = gt;
    gt_rise = gt & ~r.gt_prev;
    gt_fall = ~gt & r.gt_prev;
    // Arm on the first incrementing edge after go, drop on trailing edge
    if (!(cfg.single && cfg.go)) begin
      n.sp_run = 1'b0;
    end else if (gt_rise) begin
      n.sp_run = 1'b1;
    end else if (gt_fall) begin
      n.sp_run = 1'b0;
    end
    go_clear = cfg.single && r.sp_run && gt_fall;
    // Toggle and single pulse chain, giving one full source period
    gate_q = cfg.single ? (gt & (r.sp_run | (cfg.go & gt_rise))) : gt;
    gate_level = gate_q;
    count_enable = ~cfg.enable | gate_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule

/* rtl/tgp_pkg.sv */
// Package: register map, field layout, reset values and carriers of the timer gate block
package tgp_pkg;

  // ----------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------
  localparam int unsigned TGP_ADDR_W = 16;
  localparam logic [11:0] TGP_IDX_PCTRL = 12'hfca;
  localparam logic [11:0] TGP_IDX_GCTRL = 12'hfcb;
  localparam logic [11:0] TGP_IDX_TVAL = 12'hfcc;
  localparam logic [11:0] TGP_IDX_PLIMIT = 12'hfcd;
  localparam logic [11:0] TGP_IDX_IRQ = 12'hfce;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [7:0] TGP_PCTRL_RST = 8'h00;
  localparam logic [7:0] TGP_GCTRL_RST = 8'h00;
  localparam logic [7:0] TGP_TVAL_RST = 8'h00;
  localparam logic [7:0] TGP_PLIMIT_RST = 8'hff;
  localparam logic [3:0] TGP_CNT_RST = 4'h0;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned TGP_PC_PRE_LSB = 0;
  localparam int unsigned TGP_PC_PRE_MSB = 1;
  localparam int unsigned TGP_PC_ON = 2;
  localparam int unsigned TGP_PC_POST_LSB = 3;
  localparam int unsigned TGP_PC_POST_MSB = 6;
  localparam int unsigned TGP_GC_SS_LSB = 0;
  localparam int unsigned TGP_GC_SS_MSB = 1;
  localparam int unsigned TGP_GC_VAL = 2;
  localparam int unsigned TGP_GC_GO = 3;
  localparam int unsigned TGP_GC_SPM = 4;
  localparam int unsigned TGP_GC_TM = 5;
  localparam int unsigned TGP_GC_POL = 6;
  localparam int unsigned TGP_GC_GE = 7;
  localparam int unsigned TGP_IRQ_FLAG = 0;
  localparam int unsigned TGP_IRQ_EN = 1;

  // ----------------------------------------
  // Prescaler terminal counts
  // ----------------------------------------
  localparam logic [3:0] TGP_PRE_LAST_DIV1 = 4'h0;
  localparam logic [3:0] TGP_PRE_LAST_DIV4 = 4'h3;
  localparam logic [3:0] TGP_PRE_LAST_DIV16 = 4'hf;

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  localparam logic [1:0] TGP_RESP_OKAY = 2'h0;
  localparam logic [1:0] TGP_RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    TGP_SRC_PIN = 2'h0,
    TGP_SRC_AUX = 2'h1,
    TGP_SRC_MATCH = 2'h2,
    TGP_SRC_NONE = 2'h3
  } tgp_src_e;

  typedef struct packed {
    logic enable;
    logic polarity;
    logic toggle;
    logic single;
    logic go;
    tgp_src_e source;
  } tgp_gate_cfg_s;

endpackage

/* rtl/tgp_top.sv */
// Timer gate logic and 8-bit period timer behind an AXI4-Lite register slave
`timescale 1ns/1ps
module tgp_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic external_gate_pin,
  input wire logic aux_overflow,
  input wire logic [tgp_pkg::TGP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tgp_pkg::TGP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic primary_count_enable,
  output logic period_match,
  output logic period_match_pulse,
  output logic match_irq
);
  import tgp_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] pctrl;
    tgp_gate_cfg_s gcfg;
    logic [7:0] tval;
    logic [7:0] plimit;
    logic [3:0] presc;
    logic [3:0] post;
    logic match_q;
    logic flag;
    logic irq_en;
    logic aw_held;
    logic [11:0] aw_idx;
    logic aw_ok;
    logic w_held;
    logic [7:0] wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } tgp_state_s;

  tgp_state_s r;
  tgp_state_s n;
  logic gate_level;
  logic go_clear;
  logic count_en;
  logic [3:0] pre_last;
  logic tick;
  logic do_wr;
  logic wr_en;
  logic post_hit;
  logic [11:0] ar_idx;

  // ----------------------------------------
  // Address decode helpers
  // ----------------------------------------
  function automatic logic [11:0] addr_idx(input logic [TGP_ADDR_W-1:0] addr);
    addr_idx = addr[13:2];
  endfunction

  function automatic logic is_mapped(input logic [TGP_ADDR_W-1:0] addr);
    logic [11:0] idx;
    idx = addr[13:2];
    is_mapped = (addr[15:14] == 2'h0) &&
      ((idx == TGP_IDX_PCTRL) || (idx == TGP_IDX_GCTRL) || (idx == TGP_IDX_TVAL) ||
       (idx == TGP_IDX_PLIMIT) || (idx == TGP_IDX_IRQ));
  endfunction

  function automatic logic [3:0] pre_last_of(input logic [1:0] sel);
    if (sel[1]) begin
      pre_last_of = TGP_PRE_LAST_DIV16;
    end else if (sel[0]) begin
      pre_last_of = TGP_PRE_LAST_DIV4;
    end else begin
      pre_last_of = TGP_PRE_LAST_DIV1;
    end
  endfunction

  // ----------------------------------------
  // Gate path
  // ----------------------------------------
  tgp_gate u_gate (
    .clk(clk),
    .reset(reset),
    .external_gate_pin(external_gate_pin),
    .aux_overflow(aux_overflow),
    .match_pulse(r.match_q),
    .cfg(r.gcfg),
    .count_enable(count_en),
    .gate_level(gate_level),
    .go_clear(go_clear)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.match_q = 1'b0;
    ar_idx = addr_idx(s_axi_araddr);

    // Period timer and prescaler
    pre_last = pre_last_of(r.pctrl[TGP_PC_PRE_MSB:TGP_PC_PRE_LSB]);
    tick = r.pctrl[TGP_PC_ON] && (r.presc == pre_last);
    if (r.pctrl[TGP_PC_ON]) begin
      n.presc = tick ? TGP_CNT_RST : r.presc + 4'h1;
    end
    post_hit = 1'b0;
    if (tick) begin
      if (r.tval == r.plimit) begin
        // Match restarts the count from zero on this tick
        n.tval = TGP_TVAL_RST;
        n.match_q = 1'b1;
        if (r.post == r.pctrl[TGP_PC_POST_MSB:TGP_PC_POST_LSB]) begin
          n.post = TGP_CNT_RST;
          post_hit = 1'b1;
        end else begin
          n.post = r.post + 4'h1;
        end
      end else begin
        n.tval = r.tval + 8'h01;
      end
    end
    n.flag = r.flag | post_hit;

    // Single-pulse completion
    if (go_clear) begin
      n.gcfg.go = 1'b0;
    end

    // Write channel capture, address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_held = 1'b1;
      n.aw_idx = addr_idx(s_axi_awaddr);
      n.aw_ok = is_mapped(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wlane = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // Register write, one cycle after both halves are held
    do_wr = r.aw_held && r.w_held && !r.bvalid;
    wr_en = do_wr && r.aw_ok && r.wlane;
    if (do_wr) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = r.aw_ok ? TGP_RESP_OKAY : TGP_RESP_SLVERR;
    end
    if (wr_en) begin
      unique case (r.aw_idx)
        TGP_IDX_PCTRL: begin
          // Control write keeps the timer value
          n.pctrl = {1'b0, r.wdata[6:0]};
          n.presc = TGP_CNT_RST;
          n.post = TGP_CNT_RST;
        end
        TGP_IDX_GCTRL: begin
          n.gcfg.enable = r.wdata[TGP_GC_GE];
          n.gcfg.polarity = r.wdata[TGP_GC_POL];
          n.gcfg.toggle = r.wdata[TGP_GC_TM];
          n.gcfg.single = r.wdata[TGP_GC_SPM];
          // Software set of go wins over a same-cycle hardware clear
          n.gcfg.go = r.wdata[TGP_GC_GO] | (r.gcfg.go & ~go_clear);
          n.gcfg.source = tgp_src_e'(r.wdata[TGP_GC_SS_MSB:TGP_GC_SS_LSB]);
        end
        TGP_IDX_TVAL: begin
          n.tval = r.wdata;
          n.presc = TGP_CNT_RST;
          n.post = TGP_CNT_RST;
        end
        TGP_IDX_PLIMIT: begin
          n.plimit = r.wdata;
        end
        TGP_IDX_IRQ: begin
          // A postscaler hit arriving with the clear still sets the flag
          n.flag = r.wdata[TGP_IRQ_FLAG] | post_hit;
          n.irq_en = r.wdata[TGP_IRQ_EN];
        end
        default: begin
          n.pctrl = r.pctrl;
        end
      endcase
    end
    if (!n.gcfg.single) begin
      n.gcfg.go = 1'b0;
    end

    // Read channel
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = is_mapped(s_axi_araddr) ? TGP_RESP_OKAY : TGP_RESP_SLVERR;
      n.rdata = 8'h00;
      if (is_mapped(s_axi_araddr)) begin
        unique case (ar_idx)
          TGP_IDX_PCTRL: n.rdata = r.pctrl;
          TGP_IDX_GCTRL: n.rdata = {r.gcfg.enable, r.gcfg.polarity, r.gcfg.toggle,
                                    r.gcfg.single, r.gcfg.go, gate_level,
                                    r.gcfg.source};
          TGP_IDX_TVAL: n.rdata = r.tval;
          TGP_IDX_PLIMIT: n.rdata = r.plimit;
          TGP_IDX_IRQ: n.rdata = {6'h00, r.irq_en, r.flag};
          default: n.rdata = 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.pctrl <= TGP_PCTRL_RST;
      r.gcfg <= tgp_gate_cfg_s'(TGP_GCTRL_RST[6:0]);
      r.tval <= TGP_TVAL_RST;
      r.plimit <= TGP_PLIMIT_RST;
      r.presc <= TGP_CNT_RST;
      r.post <= TGP_CNT_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // One write and one read at a time keeps the slave free of queues
  assign s_axi_awready = !r.aw_held && !r.bvalid;
  assign s_axi_wready = !r.w_held && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = {24'h00_0000, r.rdata};
  assign primary_count_enable = count_en;
  assign period_match = (r.tval == r.plimit);
  assign period_match_pulse = r.match_q;
  assign match_irq = r.flag & r.irq_en;

endmodule
